// [bench/adc_ctrl_chk.sv]
// port checks for the converter power and channel control block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module adc_ctrl_chk (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // inputs
  input wire converter_power_on_i,
  input wire conversion_done_irq_enable_i,
  input wire watchdog_irq_enable_i,
  input wire overrun_irq_enable_i,
  // outputs
  input wire powered_o,
  input wire start_bit_o,
  input wire busy_o,
  input wire done_flag_o,
  input wire watchdog_flag_o,
  input wire overrun_flag_o,
  input wire done_irq_o,
  input wire watchdog_irq_o,
  input wire overrun_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_reset_clears: assert property (disable iff (1'b0)
    sys_rst_i |=> !powered_o && !busy_o && !done_flag_o)
    else $error("state not cleared by reset");
  chk_power_up: assert property (converter_power_on_i |=> powered_o)
    else $error("power-on did not wake the converter");
  chk_power_down: assert property (
    !converter_power_on_i [*2] |-> !busy_o && !powered_o)
    else $error("converter still active after power-off");
  chk_start_dropped: assert property (
    start_bit_o && !converter_power_on_i |=> !start_bit_o)
    else $error("start kept while powered down");
  chk_flags_frozen: assert property (!converter_power_on_i |=>
    $stable(done_flag_o) && $stable(watchdog_flag_o)
    && $stable(overrun_flag_o))
    else $error("flag moved while powered down");
  chk_done_irq: assert property (
    done_irq_o == (done_flag_o && conversion_done_irq_enable_i))
    else $error("done interrupt wrong");
  chk_wd_irq: assert property (
    watchdog_irq_o == (watchdog_flag_o && watchdog_irq_enable_i))
    else $error("watchdog interrupt wrong");
  chk_ovr_irq: assert property (
    overrun_irq_o == (overrun_flag_o && overrun_irq_enable_i))
    else $error("overrun interrupt wrong");
  cover property ($rose(done_flag_o));
  cover property ($rose(overrun_flag_o));
  cover property ($fell(busy_o) && !converter_power_on_i);
endmodule

// [bench/analog_source_model.sv]
// comparator model standing in front of the converter
// assumes chan_i and powered_i come from the control block's outputs
`timescale 1ns/1ps
module analog_source_model (
  // clock
  input wire clk_i,
  // from the block
  input wire powered_i,
  input wire [4:0] chan_i,
  // comparator
  output logic comp_o
);
  initial comp_o = 1'b0;
  // even channels sit at full scale, odd ones at zero
  // unpowered front end gives noise, so a stale level never helps
  always @(posedge clk_i) begin
    comp_o <= powered_i ? ~chan_i[0] : ~comp_o;
  end
endmodule

// [bench/testbench.sv]
// self-checking bench for the converter power and channel control block
// assumes the comparator model answers by channel number
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, dma_ack_i = 1'b0;
  logic converter_power_on_i = 1'b0, start_set_i = 1'b0, cont_mode_i = 1'b0;
  logic [1:0] res_sel_i = 2'h0;
  logic conversion_done_irq_enable_i = 1'b1, watchdog_irq_enable_i = 1'b1;
  logic overrun_irq_enable_i = 1'b1, converter_clock_halve_i = 1'b0;
  logic [2:0] slow_sample_time_sel_i = 3'h0, fast_sample_time_sel_i = 3'h0;
  logic [4:0] watchdog_chan_i = 5'h00;
  logic [29:0] chan_mask_i = 30'h1;
  logic scan_dma_i = 1'b0, done_clr_i = 1'b0, watchdog_clr_i = 1'b0;
  logic overrun_clr_i = 1'b0, comp_i;
  logic [11:0] thresh_high_i = 12'h800, thresh_low_i = 12'h100;
  wire sample_o, powered_o, data_valid_o, start_bit_o, busy_o, done_flag_o;
  wire watchdog_flag_o, overrun_flag_o, done_irq_o, watchdog_irq_o;
  wire overrun_irq_o;
  wire [4:0] chan_o;
  wire [11:0] data_o;
  int err_count = 0, tests_run = 0, n;
  always #4 clk_i = ~clk_i;
  adc_power_and_channel_control dut (.*);
  analog_source_model src (.clk_i(clk_i), .powered_i(powered_o),
    .chan_i(chan_o), .comp_o(comp_i));
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one start pulse, then count sampling cycles until the result
  task automatic conv(output int len);
    len = 0;
    n = 0;
    start_set_i = 1'b1;
    @(negedge clk_i) start_set_i = 1'b0;
    while (data_valid_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
      if (sample_o === 1'b1) len++;
    end
    cmp("conversion end", 12'h1, 12'(n < 3000));
  endtask
  task automatic power(input logic on);
    converter_power_on_i = on;
    repeat (6) @(negedge clk_i); // wait out power_up_delay
  endtask
  task automatic clr_all;
    {done_clr_i, watchdog_clr_i, overrun_clr_i} = 3'h7;
    @(negedge clk_i) {done_clr_i, watchdog_clr_i, overrun_clr_i} = 3'h0;
  endtask
  task automatic t_gate;
    start_set_i = 1'b1;
    repeat (10) @(negedge clk_i);
    start_set_i = 1'b0;
    cmp("busy while off", 12'h0, 12'(busy_o));
    cmp("flag while off", 12'h0, 12'(done_flag_o));
    power(1'b1);
    cmp("powered", 12'h1, 12'(powered_o));
    $display("test gate done");
  endtask
  task automatic t_single;
    int l;
    for (int r = 0; r < 4; r++) begin
      res_sel_i = r[1:0];
      conv(l);
      cmp("result", 12'hFFF << (2 * r), data_o);
    end
    cmp("start bit", 12'h0, 12'(start_bit_o));
    cmp("done irq", 12'h1, 12'(done_irq_o));
    cmp("watchdog irq", 12'h1, 12'(watchdog_irq_o));
    clr_all;
    cmp("flags cleared", 12'h0, 12'({done_flag_o, watchdog_flag_o}));
    $display("test single done");
  endtask
  task automatic t_smp(input string nm, input logic [29:0] m, input logic hv,
      input logic [2:0] sa, fa, sb, fb, input int d);
    int la, lb;
    chan_mask_i = m;
    converter_clock_halve_i = hv;
    {slow_sample_time_sel_i, fast_sample_time_sel_i} = {sa, fa};
    conv(la);
    {slow_sample_time_sel_i, fast_sample_time_sel_i} = {sb, fb};
    conv(lb);
    cmp(nm, d[11:0], 12'(la - lb));
  endtask
  task automatic t_abort;
    chan_mask_i = 30'h1;
    converter_clock_halve_i = 1'b0;
    clr_all;
    start_set_i = 1'b1;
    repeat (3) @(negedge clk_i) start_set_i = 1'b0;
    cmp("busy before off", 12'h1, 12'(busy_o));
    start_set_i = 1'b1;
    @(negedge clk_i) converter_power_on_i = 1'b0;
    start_set_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp("busy after off", 12'h0, 12'({busy_o, start_bit_o}));
    done_clr_i = 1'b1;
    @(negedge clk_i) done_clr_i = 1'b0;
    power(1'b1);
    $display("test abort done");
  endtask
  task automatic t_cont;
    chan_mask_i = 30'h3;
    cont_mode_i = 1'b1;
    start_set_i = 1'b1;
    @(negedge clk_i) start_set_i = 1'b0;
    for (n = 0; n < 4000 && overrun_flag_o !== 1'b1; n++) @(negedge clk_i);
    cmp("overrun irq", 12'h1, 12'(overrun_irq_o));
    cont_mode_i = 1'b0;
    for (n = 0; n < 2000 && busy_o !== 1'b0; n++) @(negedge clk_i);
    cmp("sequence stop", 12'h0, 12'(busy_o));
    cmp("sequence done", 12'h1, 12'(done_flag_o));
    $display("test continuous done");
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    t_gate;
    t_single;
    t_smp("slow field", 30'h8, 1'b0, 3'h1, 3'h0, 3'h0, 3'h0, 5);
    t_smp("fast field", 30'h2000000, 1'b0, 3'h7, 3'h1, 3'h7, 3'h0, 5);
    t_smp("vref field", 30'h10000000, 1'b0, 3'h7, 3'h1, 3'h7, 3'h0, 5);
    t_smp("temp field", 30'h20000000, 1'b0, 3'h7, 3'h1, 3'h7, 3'h0, 5);
    t_smp("halved clock", 30'h8, 1'b1, 3'h1, 3'h0, 3'h0, 3'h0, 10);
    t_abort;
    t_cont;
    report_and_stop;
  end
  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end
endmodule
bind adc_power_and_channel_control adc_ctrl_chk u_chk (.*);

// [hw/adc_ctrl_consts.vh]
// constants for the converter power and channel control block
// assumes inclusion by bare name from files under hw/
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
`define RES_W 2
`define RES_12 2'h0
`define RES_10 2'h1
`define RES_8 2'h2
`define RES_6 2'h3
`define DATA_W 12
`define CH_W 5
`define CH_SLOW_LAST 5'h17
`define CH_FAST_FIRST 5'h18
`define CH_FAST_LAST 5'h1B
`define CH_VREF 5'h1C
`define CH_TEMP 5'h1D
`define SMP_W 3
`define SMP_RST 3'h0
`define SMP_CNT_W 8
`define CONV_BITS_CNT 5'h0C
`endif

// [hw/adc_power_and_channel_control.v]
// converter power and channel control: power, start, sequence, flags
// assumes software-side ports are synchronous; analog result is a pin
//
// Overview of operation
// [RULE1] setting power-on wakes the converter from power-down
// [RULE2] software starts only after power-up delay, before idle delay ends
// [RULE3] clearing power-on stops conversion and powers down
// [RULE4] slow channels 0 to 23 use the slow sampling-time field
// [RULE5] fast channels 24 to 27 use the fast sampling-time field
// [RULE6] internal reference and temperature channels use the fast field
// [RULE7] resolution selectable, widest gives 12-bit data
// [RULE8] single or continuous conversion mode by configuration
// [RULE9] separate interrupts for done, watchdog and overrun
// [RULE10] channel selector addresses up to 30 channels
// [RULE11] scan mode converts several selected channels, results to DMA
// [RULE12] fast-channel conversion can finish in about 1 us at 16 MHz
// [RULE13] start bit launches conversion; hardware clears it when accepted
// [RULE14] done flag set at conversion end, interrupt when enabled
// [RULE15] prescaler bit selects converter clock or that clock halved
// [RULE16] powered down: starts ignored, flags frozen
// [RULE17] reset clears power-on, sampling fields at default
`timescale 1ns/1ps
module adc_power_and_channel_control (
  // clock, reset, enable
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // control one
  input wire converter_power_on_i,
  input wire start_set_i,
  input wire cont_mode_i,
  input wire [1:0] res_sel_i,
  input wire conversion_done_irq_enable_i,
  input wire watchdog_irq_enable_i,
  input wire overrun_irq_enable_i,
  // control two
  input wire [2:0] slow_sample_time_sel_i,
  input wire converter_clock_halve_i,
  // control three
  input wire [2:0] fast_sample_time_sel_i,
  input wire [4:0] watchdog_chan_i,
  // sequence select and thresholds
  input wire [29:0] chan_mask_i,
  input wire scan_dma_i,
  input wire [11:0] thresh_high_i,
  input wire [11:0] thresh_low_i,
  // flag clears and dma
  input wire done_clr_i,
  input wire watchdog_clr_i,
  input wire overrun_clr_i,
  input wire dma_ack_i,
  // analog front end
  input wire comp_i,
  output reg sample_o,
  output reg [4:0] chan_o,
  output reg powered_o,
  // results and status
  output reg [11:0] data_o,
  output reg data_valid_o,
  output wire start_bit_o,
  output wire busy_o,
  output reg done_flag_o,
  output reg watchdog_flag_o,
  output reg overrun_flag_o,
  // interrupts
  output wire done_irq_o,
  output wire watchdog_irq_o,
  output wire overrun_irq_o
);
`include "adc_ctrl_consts.vh"
  localparam S_OFF = 4'h1;
  localparam S_IDLE = 4'h2;
  localparam S_SAMP = 4'h4;
  localparam S_CONV = 4'h8;

  reg [3:0] state_r;
  reg start_r;
  reg comp_m_r;
  reg comp_s_r;
  reg [7:0] cnt_r;
  reg [4:0] bit_r;
  reg [11:0] sar_r;
  reg [29:0] pend_r;
  reg dma_wait_r;
  wire tick;
  wire [7:0] smp_len;

  // lowest pending channel of the sequence
  function [4:0] first_chan;
    input [29:0] m;
    integer k;
    begin
      first_chan = 5'h00;
      for (k = 29; k >= 0; k = k - 1) begin
        if (m[k]) begin
          first_chan = k[4:0];
        end
      end
    end
  endfunction

  // number of result bits for the resolution setting
  function [4:0] res_bits;
    input [1:0] r;
    begin
      case (r)
        `RES_12: res_bits = `CONV_BITS_CNT;
        `RES_10: res_bits = 5'h0A;
        `RES_8: res_bits = 5'h08;
        default: res_bits = 5'h06;
      endcase
    end
  endfunction

  sample_time_sel u_smp (
    .chan_i(chan_o),
    .slow_sel_i(slow_sample_time_sel_i),
    .fast_sel_i(fast_sample_time_sel_i),
    .cycles_o(smp_len)
  );

  conv_clk_gen u_clk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .halve_i(converter_clock_halve_i),
    // divider held clear while not busy so halved timing is repeatable
    .run_i(converter_power_on_i & busy_o),
    .tick_o(tick)
  );

  wire powered = (state_r != S_OFF);
  wire [29:0] sel_mask = (chan_mask_i == 30'h0) ? 30'h1 : chan_mask_i;
  wire [29:0] one_mask = 30'h1 << first_chan(sel_mask);
  wire bit_last = (bit_r == 5'h01);
  wire conv_end = (state_r == S_CONV) & tick & bit_last;
  wire [29:0] rest = pend_r & ~(30'h1 << chan_o);
  // msb-aligned result trimmed to the resolution, low bits zero
  wire [11:0] trial = sar_r | (12'h800 >> (res_bits(res_sel_i) - bit_r));
  wire [11:0] res_val = comp_s_r ? trial : sar_r;
  wire wd_out = (chan_o == watchdog_chan_i) &
                ((res_val > thresh_high_i) | (res_val < thresh_low_i));

  assign start_bit_o = start_r;
  assign busy_o = (state_r == S_SAMP) | (state_r == S_CONV);
  // separate interrupt lines [RULE9] [RULE14]
  assign done_irq_o = done_flag_o & conversion_done_irq_enable_i;
  assign watchdog_irq_o = watchdog_flag_o & watchdog_irq_enable_i;
  assign overrun_irq_o = overrun_flag_o & overrun_irq_enable_i;

  // comparator crosses from the analog side: two flip-flops first
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      comp_m_r <= 1'b0;
      comp_s_r <= 1'b0;
    end else if (ce_i) begin
      comp_m_r <= comp_i;
      comp_s_r <= comp_m_r;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= S_OFF; // [RULE17]
      start_r <= 1'b0;
      cnt_r <= 8'h00;
      bit_r <= 5'h00;
      sar_r <= 12'h000;
      pend_r <= 30'h0;
      chan_o <= 5'h00;
      sample_o <= 1'b0;
      powered_o <= 1'b0;
      data_o <= 12'h000;
      data_valid_o <= 1'b0;
      dma_wait_r <= 1'b0;
      done_flag_o <= 1'b0;
      watchdog_flag_o <= 1'b0;
      overrun_flag_o <= 1'b0;
    end else if (ce_i) begin
      powered_o <= converter_power_on_i;
      data_valid_o <= 1'b0;
      if (!converter_power_on_i) begin
        // abort everything, flags hold [RULE3] [RULE16]
        state_r <= S_OFF;
        start_r <= 1'b0;
        sample_o <= 1'b0;
        pend_r <= 30'h0;
      end else begin
        if (dma_ack_i) begin
          dma_wait_r <= 1'b0;
        end
        // set wins over clear on every flag
        if (done_clr_i) begin
          done_flag_o <= 1'b0;
        end
        if (watchdog_clr_i) begin
          watchdog_flag_o <= 1'b0;
        end
        if (overrun_clr_i) begin
          overrun_flag_o <= 1'b0;
        end
        if (start_set_i & (state_r != S_OFF)) begin
          start_r <= 1'b1; // [RULE13]
        end
        case (state_r)
          S_OFF: begin
            state_r <= S_IDLE; // [RULE1]
          end
          S_IDLE: begin
            // waiting out power-up delay is left to software [RULE2]
            if (start_r | start_set_i) begin
              start_r <= 1'b0; // accepted, cleared by hardware [RULE13]
              // scan or continuous takes whole mask, otherwise one [RULE11] [RULE10]
              pend_r <= (scan_dma_i | cont_mode_i) ? sel_mask : one_mask;
              chan_o <= first_chan(sel_mask);
              cnt_r <= 8'h00;
              sample_o <= 1'b1;
              state_r <= S_SAMP;
            end
          end
          S_SAMP: begin
            if (tick) begin
              // per-channel sampling length [RULE4] [RULE5] [RULE6]
              if (cnt_r + 8'h01 >= smp_len) begin
                sample_o <= 1'b0;
                sar_r <= 12'h000;
                bit_r <= res_bits(res_sel_i); // [RULE7]
                state_r <= S_CONV;
              end else begin
                cnt_r <= cnt_r + 8'h01;
              end
            end
          end
          S_CONV: begin
            // one result bit per converter clock keeps 1 us reachable
            if (tick) begin
              sar_r <= res_val; // [RULE12]
              bit_r <= bit_r - 5'h01;
            end
            if (conv_end) begin
              data_o <= res_val;
              data_valid_o <= 1'b1;
              if (wd_out) begin
                watchdog_flag_o <= 1'b1; // [RULE9]
              end
              if (scan_dma_i | cont_mode_i) begin
                if (dma_wait_r & ~dma_ack_i) begin
                  overrun_flag_o <= 1'b1; // [RULE9] [RULE11]
                end
                dma_wait_r <= 1'b1;
              end
              cnt_r <= 8'h00;
              if (rest != 30'h0) begin
                chan_o <= first_chan(rest);
                pend_r <= rest;
                sample_o <= 1'b1;
                state_r <= S_SAMP;
              end else begin
                done_flag_o <= 1'b1; // [RULE14]
                if (cont_mode_i) begin
                  // continuous restarts the sequence [RULE8]
                  pend_r <= sel_mask;
                  chan_o <= first_chan(sel_mask);
                  sample_o <= 1'b1;
                  state_r <= S_SAMP;
                end else begin
                  pend_r <= 30'h0;
                  state_r <= S_IDLE; // [RULE8]
                end
              end
            end
          end
          default: begin
            state_r <= S_OFF;
          end
        endcase
      end
    end
  end
endmodule

// [hw/conv_clk_gen.v]
// converter clock enable: every cycle, or every other cycle
// assumes one clock; the divider is a tick, not a new clock domain
`timescale 1ns/1ps
module conv_clk_gen (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  // control
  input wire halve_i,
  input wire run_i,
  // tick
  output wire tick_o
);
  reg phase_r;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_r <= 1'b0;
    end else if (ce_i) begin
      phase_r <= run_i ? ~phase_r : 1'b0;
    end
  end
  // halved clock ticks on alternate cycles only [RULE15]
  assign tick_o = run_i & (~halve_i | phase_r);
endmodule

// [hw/sample_time_sel.v]
// picks the sampling-time field for a channel and maps it to clocks
// assumes channel numbers come from the same clock domain
`timescale 1ns/1ps
module sample_time_sel (
  // channel and fields
  input wire [4:0] chan_i,
  input wire [2:0] slow_sel_i,
  input wire [2:0] fast_sel_i,
  // sampling length in converter clocks
  output wire [7:0] cycles_o
);
`include "adc_ctrl_consts.vh"
  function [7:0] smp_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: smp_cycles = 8'h04;
        3'h1: smp_cycles = 8'h09;
        3'h2: smp_cycles = 8'h10;
        3'h3: smp_cycles = 8'h18;
        3'h4: smp_cycles = 8'h30;
        3'h5: smp_cycles = 8'h60;
        3'h6: smp_cycles = 8'hC0;
        default: smp_cycles = 8'hFF;
      endcase
    end
  endfunction
  // slow group 0..23, all else fast or internal [RULE4] [RULE5] [RULE6]
  wire is_slow = (chan_i <= `CH_SLOW_LAST);
  assign cycles_o = smp_cycles(is_slow ? slow_sel_i : fast_sel_i);
endmodule
